// >>> oss_defines.svh
// Offsets, field positions, reset values and timing counts of the output safe-state block.
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH

`define OSS_NCH            16
`define OSS_ADDR_W         8
`define OSS_DATA_W         16

`define OSS_ADR_CFG_LAST   8'h0F
`define OSS_ADR_DRIVE      8'h10
`define OSS_ADR_NO_LOAD    8'h11
`define OSS_ADR_STATUS     8'h12

`define OSS_B_FAULT_SEL    0
`define OSS_B_FAULT_LVL    1
`define OSS_B_PROG_SEL     2
`define OSS_B_PROG_LVL     3
`define OSS_B_FINAL_LVL    4
`define OSS_B_PROG2FAULT   5
`define OSS_B_LOAD_DET     6
`define OSS_B_HOLD_LSB     8
`define OSS_B_HOLD_MSB     15

`define OSS_B_ST_LINK      0
`define OSS_B_ST_DIAG      1
`define OSS_B_ST_UNCERT    2

`define OSS_CFG_RESET      16'h0000
`define OSS_DRIVE_RESET    16'h0000

`define OSS_HOLD_CODE_1    8'h01
`define OSS_HOLD_CODE_2    8'h02
`define OSS_HOLD_CODE_5    8'h05
`define OSS_HOLD_CODE_10   8'h0A
`define OSS_SECS_W         4

`define OSS_CLK_PERIOD_NS  25
`define OSS_TICK_MS        1000
`define OSS_TICK_CYCLES    ((`OSS_TICK_MS * 1000000) / `OSS_CLK_PERIOD_NS)
`define OSS_SUB_W          26

`endif

// >>> oss_pkg.sv
// Types shared by the output safe-state block.
`default_nettype none
`include "oss_defines.svh"

package oss_pkg;

    typedef enum logic [1:0] {CH_RUN, CH_PROG, CH_FAULT, CH_FINAL} oss_chmode_t;

    typedef logic [`OSS_NCH-1:0][`OSS_DATA_W-1:0] oss_cfg_arr_t;

    typedef struct packed {
        oss_chmode_t [`OSS_NCH-1:0]                 mode;
        logic [`OSS_NCH-1:0][`OSS_SUB_W-1:0]        sub;
        logic [`OSS_NCH-1:0][`OSS_SECS_W-1:0]       secs;
        logic [`OSS_NCH-1:0]                        drive;
        logic [`OSS_NCH-1:0]                        no_load;
        logic                                       link_lost;
        logic                                       diag;
        logic                                       uncertain;
        logic [`OSS_DATA_W-1:0]                     rdata;
    } oss_state_t;

    typedef struct packed {
        oss_cfg_arr_t words;
    } oss_mem_state_t;

    // Codes other than the four listed ones fall back to holding forever.
    function automatic logic [`OSS_SECS_W-1:0] oss_hold_secs(input logic [7:0] code);
        logic [`OSS_SECS_W-1:0] secs;
        secs = 4'h0;
        if (code == `OSS_HOLD_CODE_1)
            secs = 4'h1;
        else if (code == `OSS_HOLD_CODE_2)
            secs = 4'h2;
        else if (code == `OSS_HOLD_CODE_5)
            secs = 4'h5;
        else if (code == `OSS_HOLD_CODE_10)
            secs = 4'hA;
        return secs;
    endfunction

endpackage

`default_nettype wire

// >>> oss_cfg_if.sv
// Carrier between the safe-state control and its per-channel configuration store.
`default_nettype none
`include "oss_defines.svh"

interface oss_cfg_if;
    import oss_pkg::*;

    logic                    wr;
    logic [3:0]              idx;
    logic [`OSS_DATA_W-1:0]  wdata;
    oss_cfg_arr_t            words;

    modport ctrl (output wr, output idx, output wdata, input words);
    modport mem  (input wr, input idx, input wdata, output words);
endinterface

`default_nettype wire

// >>> oss_cfg_mem.sv
// Sixteen-word configuration store, one word per output channel, all words held in flops.
`default_nettype none
`include "oss_defines.svh"

module oss_cfg_mem
    import oss_pkg::*;
(
    input  wire logic  clk,    // Module clock.
    input  wire logic  nrst,   // Asynchronous reset, active low.
    oss_cfg_if.mem     cfg     // Write port and word read-out.
);

    oss_mem_state_t st;
    oss_mem_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (cfg.wr)
        begin
            next_st.words[cfg.idx] = cfg.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '{words: {`OSS_NCH{`OSS_CFG_RESET}}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cfg.words = st.words;

endmodule

`default_nettype wire

// >>> oss_top.sv
// Per-channel safe-state control for a sixteen-point digital output module.
//
// Decided for this implementation: the register offsets and the strobed register port.
`default_nettype none
`include "oss_defines.svh"

module oss_top
    import oss_pkg::*;
#(
    parameter int TICK_CYCLES = `OSS_TICK_CYCLES  // Cycles in one second of hold time.
)
(
    input  wire logic                     clk,               // Module clock, 40 MHz.
    input  wire logic                     nrst,              // Asynchronous reset, active low.
    input  wire logic [`OSS_ADDR_W-1:0]   addr,              // Register word address.
    input  wire logic [`OSS_DATA_W-1:0]   wdata,             // Register write data.
    input  wire logic                     wr,                // Write strobe.
    input  wire logic                     rd,                // Read strobe.
    output var  logic [`OSS_DATA_W-1:0]   rdata,             // Read data, cycle after rd.
    input  wire logic                     link_up,           // Connection to owner running.
    input  wire logic                     run_state,         // Owner in run mode, else program.
    input  wire logic [`OSS_NCH-1:0]      cmd_data,          // Commanded output bits.
    input  wire logic [`OSS_NCH-1:0]      load_open,         // Sense: no load current seen.
    input  wire logic                     prognostic_hit,    // Prognostics threshold reached.
    input  wire logic                     diag_ext,          // Other diagnostic condition.
    input  wire logic                     out_of_range,      // Outside designed range.
    input  wire logic                     override_active,   // Data under manual or override.
    output var  logic [`OSS_NCH-1:0]      out_drive,         // Output driver levels.
    output var  logic [`OSS_NCH-1:0]      missing_load_flag, // Per-channel missing load.
    output var  logic                     link_lost,         // No connection running.
    output var  logic                     diag_present,      // Any diagnostic active.
    output var  logic                     module_uncertain   // Module data uncertain.
);

    localparam logic [`OSS_SUB_W-1:0] SUB_LAST = `OSS_SUB_W'(TICK_CYCLES - 1);

    oss_cfg_if cfg_bus ();

    oss_state_t st;
    oss_state_t next_st;

    logic [`OSS_NCH-1:0] next_no_load;

    oss_cfg_mem u_cfg_mem (
        .clk  (clk),
        .nrst (nrst),
        .cfg  (cfg_bus)
    );

    // Configuration words are writable at any time; a change takes effect on the next edge.
    assign cfg_bus.wr    = wr && (addr <= `OSS_ADR_CFG_LAST);
    assign cfg_bus.idx   = addr[3:0];
    assign cfg_bus.wdata = wdata;

    always_comb
    begin
        next_st      = st;
        next_no_load = '0;

        for (int i = 0; i < `OSS_NCH; i++)
        begin
            logic [`OSS_DATA_W-1:0] w;
            logic [`OSS_SECS_W-1:0] hold;
            logic                   enter_fault;
            w           = cfg_bus.words[i];
            hold        = oss_hold_secs(w[`OSS_B_HOLD_MSB:`OSS_B_HOLD_LSB]);
            enter_fault = 1'b0;

            if (link_up && run_state)
            begin
                next_st.mode[i]  = CH_RUN;
                next_st.drive[i] = cmd_data[i];
            end
            else if (link_up)
            begin
                // Program mode; hold-last keeps whatever the channel last drove.
                next_st.mode[i] = CH_PROG;
                if (w[`OSS_B_PROG_SEL])
                begin
                    next_st.drive[i] = w[`OSS_B_PROG_LVL];
                end
            end
            else
            begin
                unique case (st.mode[i])
                    CH_RUN:
                    begin
                        enter_fault = 1'b1;
                    end
                    CH_PROG:
                    begin
                        if (w[`OSS_B_PROG2FAULT])
                        begin
                            enter_fault = 1'b1;
                        end
                        else if (w[`OSS_B_PROG_SEL])
                        begin
                            next_st.drive[i] = w[`OSS_B_PROG_LVL];
                        end
                    end
                    CH_FAULT:
                    begin
                        if (w[`OSS_B_FAULT_SEL])
                        begin
                            next_st.drive[i] = w[`OSS_B_FAULT_LVL];
                        end
                        // A zero hold code leaves the channel in fault state forever.
                        if (hold != '0)
                        begin
                            if (st.sub[i] == SUB_LAST)
                            begin
                                next_st.sub[i] = '0;
                                if (st.secs[i] + 4'h1 >= hold)
                                begin
                                    next_st.mode[i]  = CH_FINAL;
                                    next_st.drive[i] = w[`OSS_B_FINAL_LVL];
                                end
                                else
                                begin
                                    next_st.secs[i] = st.secs[i] + 4'h1;
                                end
                            end
                            else
                            begin
                                next_st.sub[i] = st.sub[i] + `OSS_SUB_W'(1);
                            end
                        end
                    end
                    CH_FINAL:
                    begin
                        next_st.drive[i] = st.drive[i];
                    end
                endcase
            end

            // The timer restarts at every entry so each channel times its own fault.
            if (enter_fault)
            begin
                next_st.mode[i] = CH_FAULT;
                next_st.sub[i]  = '0;
                next_st.secs[i] = '0;
                if (w[`OSS_B_FAULT_SEL])
                begin
                    next_st.drive[i] = w[`OSS_B_FAULT_LVL];
                end
            end

            next_no_load[i] = w[`OSS_B_LOAD_DET] && load_open[i];
        end

        next_st.no_load   = next_no_load;
        next_st.link_lost = !link_up;
        next_st.diag      = (|next_no_load) || prognostic_hit || diag_ext;
        next_st.uncertain = out_of_range || override_active;

        // Unmapped addresses read as zero; reads have no side effects.
        next_st.rdata = '0;
        if (rd)
        begin
            if (addr <= `OSS_ADR_CFG_LAST)
            begin
                next_st.rdata = cfg_bus.words[addr[3:0]];
            end
            else if (addr == `OSS_ADR_DRIVE)
            begin
                next_st.rdata = st.drive;
            end
            else if (addr == `OSS_ADR_NO_LOAD)
            begin
                next_st.rdata = st.no_load;
            end
            else if (addr == `OSS_ADR_STATUS)
            begin
                next_st.rdata[`OSS_B_ST_LINK]   = st.link_lost;
                next_st.rdata[`OSS_B_ST_DIAG]   = st.diag;
                next_st.rdata[`OSS_B_ST_UNCERT] = st.uncertain;
            end
        end
    end

    // Channels start as if their hold time had already expired with outputs off,
    // so nothing is driven before the owner first connects.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st.mode      <= '{default: CH_FINAL};
            st.sub       <= '0;
            st.secs      <= '0;
            st.drive     <= `OSS_DRIVE_RESET;
            st.no_load   <= '0;
            st.link_lost <= 1'b1;
            st.diag      <= 1'b0;
            st.uncertain <= 1'b0;
            st.rdata     <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata             = st.rdata;
    assign out_drive         = st.drive;
    assign missing_load_flag = st.no_load;
    assign link_lost         = st.link_lost;
    assign diag_present      = st.diag;
    assign module_uncertain  = st.uncertain;

endmodule

`default_nettype wire

// >>> oss_top_assertions.sv
// Port-level checker for the output safe-state block.
`default_nettype none
`include "oss_defines.svh"
module oss_top_checker
#(
    parameter int TICK_CYCLES = 10  // Cycles in one hold second.
)
(
    input wire logic        clk,               // Clock.
    input wire logic        nrst,              // Reset.
    input wire logic [7:0]  addr,              // Address.
    input wire logic        rd,                // Read strobe.
    input wire logic [15:0] rdata,             // Read data.
    input wire logic        link_up,           // Link.
    input wire logic        run_state,         // Run mode.
    input wire logic [15:0] cmd_data,          // Commands.
    input wire logic [15:0] load_open,         // Load sense.
    input wire logic        prognostic_hit,    // Prognostic.
    input wire logic        diag_ext,          // Diagnostic.
    input wire logic        out_of_range,      // Range.
    input wire logic        override_active,   // Override.
    input wire logic [15:0] out_drive,         // Drivers.
    input wire logic [15:0] missing_load_flag, // Load flags.
    input wire logic        link_lost,         // Link lost.
    input wire logic        diag_present,      // Diagnostic.
    input wire logic        module_uncertain   // Uncertain.
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_run;
        link_up && run_state;
    endsequence
    // Two run cycles are required, though the drivers already take cmd_data on the edge after the first one.
    sequence s_run2;
        s_run ##1 s_run;
    endsequence
    lost_flag_a: assert property (1'b1 |=> link_lost == !$past(link_up))
        else $error("link_lost wrong");
    uncert_flag_a: assert property (1'b1 |=>
        module_uncertain == $past(out_of_range || override_active)) else $error("uncertain wrong");
    diag_flag_a: assert property (1'b1 |=> diag_present ==
        (|missing_load_flag || $past(prognostic_hit || diag_ext))) else $error("diag wrong");
    load_mask_a: assert property (1'b1 |=>
        (missing_load_flag & ~$past(load_open)) == 16'h0000) else $error("load flag wrong");
    run_follow_a: assert property (s_run2 |=> out_drive == $past(cmd_data))
        else $error("drive not following");
    rd_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("rdata not idle");
    rd_status_a: assert property (rd && addr == `OSS_ADR_STATUS |=>
        rdata == {13'h0000, $past({module_uncertain, diag_present, link_lost})})
        else $error("status read wrong");
    rd_drive_a: assert property (rd && addr == `OSS_ADR_DRIVE |=>
        rdata == $past(out_drive)) else $error("drive read wrong");
endmodule
bind oss_top oss_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk
(
    .clk(clk), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata), .link_up(link_up),
    .run_state(run_state), .cmd_data(cmd_data), .load_open(load_open),
    .prognostic_hit(prognostic_hit), .diag_ext(diag_ext), .out_of_range(out_of_range),
    .override_active(override_active), .out_drive(out_drive),
    .missing_load_flag(missing_load_flag), .link_lost(link_lost),
    .diag_present(diag_present), .module_uncertain(module_uncertain)
);
`default_nettype wire

// >>> oss_owner.sv
// Owner controller model: drives link, mode and commanded bits.
`default_nettype none
module oss_owner
(
    input  wire logic        clk,       // Clock.
    input  wire logic        want_up,   // Link wanted.
    input  wire logic        want_run,  // Run mode wanted.
    input  wire logic [15:0] want_data, // Bits to command.
    output var  logic        link_up,   // Link running.
    output var  logic        run_state, // Run mode.
    output var  logic [15:0] cmd_data   // Commanded bits.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {link_up, run_state, cmd_data} = '0;
    // A dead link carries no valid data, so the lines toggle rather than hold.
    always @(posedge clk)
    begin
        link_up   <= want_up;
        run_state <= want_up ? want_run : !run_state;
        cmd_data  <= want_up ? want_data : ~cmd_data;
    end
endmodule
`default_nettype wire

// >>> oss_tb_top.sv
// Self-checking bench for the output safe-state block.
`default_nettype none
`include "oss_defines.svh"
module oss_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0, up = 0, run = 0, link_up, run_state;
    logic        prognostic_hit = 0, diag_ext = 0, out_of_range = 0, override_active = 0;
    logic        link_lost, diag_present, module_uncertain;
    logic [7:0]  addr = '0;
    logic [15:0] wdata = '0, data = '0, load_open = '0, cmd_data, rdata, out_drive, miss;
    int          n_mismatch = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    oss_owner owner (.clk(clk), .want_up(up), .want_run(run), .want_data(data),
        .link_up(link_up), .run_state(run_state), .cmd_data(cmd_data));
    oss_top #(.TICK_CYCLES(10)) dut
    (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link_up(link_up), .run_state(run_state), .cmd_data(cmd_data),
        .load_open(load_open), .prognostic_hit(prognostic_hit), .diag_ext(diag_ext),
        .out_of_range(out_of_range), .override_active(override_active),
        .out_drive(out_drive), .missing_load_flag(miss), .link_lost(link_lost),
        .diag_present(diag_present), .module_uncertain(module_uncertain)
    );
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic drv(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk);
        #1 chk("out_drive", exp, out_drive);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`OSS_ADR_STATUS, 16'h0001);
        rd_chk(8'h00, `OSS_CFG_RESET);
        wr_reg(8'h0F, 16'h0A40);
        wr_reg(`OSS_ADR_DRIVE, 16'hFFFF);
        rd_chk(8'h0F, 16'h0A40);
        rd_chk(`OSS_ADR_DRIVE, `OSS_DRIVE_RESET);
        rd_chk(8'h20, 16'h0000);
        $display("test registers done");
        data <= 16'hF003;
        run  <= 1'b1;
        up   <= 1'b1;
        drv(4, 16'hF003);
        chk("status", 16'h0000, {13'h0000, module_uncertain, diag_present, link_lost});
        // Channel 3 carries an unlisted hold code and so must never expire.
        // Channel 4 keeps its last level and holds for the shortest legal time.
        wr_reg(8'h00, 16'h0211);
        wr_reg(8'h01, 16'h0000);
        wr_reg(8'h02, 16'h0503);
        wr_reg(8'h03, 16'h0303);
        wr_reg(8'h04, 16'h0110);
        @(posedge clk);
        up <= 1'b0;
        drv(17, 16'hF01E);
        chk("link_lost", 16'h0001, 16'(link_lost));
        drv(10, 16'hF01F);
        drv(20, 16'hF01F);
        drv(10, 16'hF01B);
        up <= 1'b1;
        drv(4, 16'hF003);
        $display("test fault done");
        wr_reg(8'h00, 16'h000C);
        wr_reg(8'h01, 16'h0027);
        wr_reg(8'h02, 16'h0000);
        wr_reg(8'h03, 16'h0000);
        data <= 16'h0006;
        drv(4, 16'h0006);
        run <= 1'b0;
        drv(4, 16'h0005);
        data <= 16'hFFFF;
        drv(4, 16'h0005);
        up <= 1'b0;
        drv(4, 16'h0007);
        $display("test program done");
        wr_reg(8'h04, 16'h0040);
        load_open <= 16'hFFFF;
        repeat (3) @(posedge clk);
        #1 chk("missing_load_flag", 16'h8010, miss);
        chk("diag_present", 16'h0001, 16'(diag_present));
        rd_chk(`OSS_ADR_NO_LOAD, 16'h8010);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {load_open, override_active, out_of_range, diag_ext, prognostic_hit} <=
                {16'h0000, 4'(1 << i)};
            repeat (3) @(posedge clk);
            #1 chk("diag_present", 16'(i < 2), 16'(diag_present));
            chk("module_uncertain", 16'(i > 1), 16'(module_uncertain));
        end
        rd_chk(`OSS_ADR_STATUS, 16'h0005);
        $display("test status done");
        print_verdict;
    end
endmodule
`default_nettype wire
